// File: shared_timer_prescaler.sv
// shared timer prescaler with clock select, external pin sampling and APB registers
//
// Our own choices: the APB register port and the address map.
`default_nettype none
`include "prescaler_defs.svh"

// How it works
// - select code 1 gives one tick every system clock cycle.
// - prescaler taps divide the system clock by 8, 64, 256 and 1024.
// - one free running prescaler serves both timers regardless of selects.
// - each timer has its own select register.
// - first prescaled tick comes 1 to N cycles after enabling.
// - a prescaler reset restarts the period for both timers.
// - the count pin is sampled each cycle then edge detected.
// - sampling registers use rising clock; latch stage modelled by first flop.
// - code 7 ticks on rising pin edges, code 6 on falling.
// - pin edge reaches the tick within 2 to 3 cycles.
// - pin ticks bypass the prescaler division.
// - hold bit set keeps reset request stored, prescaler held.
// - clearing hold bit clears reset request so timers start together.
// - reset request resets prescaler and self-clears unless hold is set.
// - capture choice 0 routes pin a, 1 routes pin b.
// - select code 0 stops the timer's ticks.
module shared_timer_prescaler
  import prescaler_pkg::*;
#(
  parameter int PRESCALE_BITS = `PRESCALE_WIDTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic external_count_pin,
  input wire logic capture_pin_a,
  input wire logic capture_pin_b,
  // to the timers
  output logic timer_zero_tick,
  output logic timer_one_tick,
  output logic capture_trigger
);

  // the tap decode below is written for exactly ten counter bits
  if (PRESCALE_BITS != 10) begin : g_width_check
    $error("prescaler must be 10 bits for the 1024 tap");
  end

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync;
  wire logic rst_ok_n = rst_sync[1];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // ****************************************
  // apb registers
  // ****************************************
  localparam logic [7:0] GTC_INIT = `GTC_RESET;
  logic sync_hold_mode;
  logic capture_input_choice;
  logic prescaler_reset_request;
  tick_source_t tick_source_select [2];

  wire logic apb_write = psel && penable && pwrite;
  wire logic hit_gtc = (paddr == `GTC_OFFSET);
  wire logic hit_sel0 = (paddr == `TICK0_SEL_OFFSET);
  wire logic hit_sel1 = (paddr == `TICK1_SEL_OFFSET);
  wire logic hit_stat = (paddr == `STATUS_OFFSET);
  wire logic hit_any = hit_gtc || hit_sel0 || hit_sel1 || hit_stat;
  wire logic gtc_write = apb_write && hit_gtc;
  wire logic next_hold = gtc_write ? pwdata[`GTC_HOLD_BIT] : sync_hold_mode;
  // a write of one always resets; it survives only while hold stays set
  wire logic next_request = gtc_write ? (pwdata[`GTC_PSR_BIT] && next_hold)
                                      : (prescaler_reset_request && sync_hold_mode);
  wire logic prescaler_clear = (gtc_write && pwdata[`GTC_PSR_BIT]) || prescaler_reset_request;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  always_ff @(posedge sys_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      sync_hold_mode <= GTC_INIT[`GTC_HOLD_BIT];
      capture_input_choice <= GTC_INIT[`GTC_CAPSEL_BIT];
      prescaler_reset_request <= GTC_INIT[`GTC_PSR_BIT];
      tick_source_select[0] <= tick_source_t'(`SEL_RESET);
      tick_source_select[1] <= tick_source_t'(`SEL_RESET);
    end else begin
      sync_hold_mode <= next_hold;
      prescaler_reset_request <= next_request;
      if (gtc_write) begin
        capture_input_choice <= pwdata[`GTC_CAPSEL_BIT];
      end
      if (apb_write && hit_sel0) begin
        tick_source_select[0] <= tick_source_t'(pwdata[2:0]);
      end
      if (apb_write && hit_sel1) begin
        tick_source_select[1] <= tick_source_t'(pwdata[2:0]);
      end
    end
  end

  // ****************************************
  // shared prescaler
  // ****************************************
  logic [PRESCALE_BITS-1:0] prescale_count;
  always_ff @(posedge sys_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      prescale_count <= '0;
    end else if (prescaler_clear) begin
      prescale_count <= '0;
    end else begin
      prescale_count <= prescale_count + 1'b1;
    end
  end

  // a tap fires on the cycle its low bits are all ones, once per period
  wire logic [3:0] taps = {
    &prescale_count[9:0], &prescale_count[7:0], &prescale_count[5:0], &prescale_count[2:0]
  };

  // ****************************************
  // count pin sampling and edges
  // ****************************************
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  always_ff @(posedge sys_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= external_count_pin;
      pin_sync <= pin_meta;
      // two sync stages plus the tick register set the pin to tick latency
      pin_prev <= pin_sync;
    end
  end
  wire logic pin_rise = pin_sync && !pin_prev;
  wire logic pin_fall = !pin_sync && pin_prev;

  // ****************************************
  // tick selection
  // ****************************************
  function automatic logic pick_tick(input tick_source_t sel, input logic [3:0] tap,
                                     input logic rise, input logic fall, input logic hold);
    logic result;
    result = 1'b0;
    unique case (sel)
      SEL_STOP: result = 1'b0;
      SEL_DIRECT: result = !hold;
      SEL_DIV8: result = tap[0] && !hold;
      SEL_DIV64: result = tap[1] && !hold;
      SEL_DIV256: result = tap[2] && !hold;
      SEL_DIV1024: result = tap[3] && !hold;
      SEL_EXT_FALL: result = fall;
      SEL_EXT_RISE: result = rise;
    endcase
    return result;
  endfunction : pick_tick

  wire logic [1:0] next_tick;
  logic [1:0] tick_q;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sel
      assign next_tick[g] = pick_tick(tick_source_select[g], taps, pin_rise, pin_fall,
                                      prescaler_clear);
    end
  endgenerate

  // two stages on each capture pin before the select mux reads them
  logic [1:0] cap_meta;
  logic [1:0] cap_sync;
  logic capture_q;
  always_ff @(posedge sys_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      tick_q <= 2'b00;
      cap_meta <= 2'b00;
      cap_sync <= 2'b00;
      capture_q <= 1'b0;
    end else begin
      tick_q <= next_tick;
      cap_meta <= {capture_pin_b, capture_pin_a};
      cap_sync <= cap_meta;
      capture_q <= capture_input_choice ? cap_sync[1] : cap_sync[0];
    end
  end
  assign timer_zero_tick = tick_q[0];
  assign timer_one_tick = tick_q[1];
  assign capture_trigger = capture_q;

  wire logic [31:0] rd_gtc = {24'h0000_00, sync_hold_mode, capture_input_choice, 5'h00,
                              prescaler_reset_request};
  wire logic [31:0] rd_stat = {22'h00_0000, prescale_count};
  always_ff @(posedge sys_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit_gtc ? rd_gtc :
                hit_sel0 ? {29'h0000_0000, tick_source_select[0]} :
                hit_sel1 ? {29'h0000_0000, tick_source_select[1]} :
                hit_stat ? rd_stat : 32'h0000_0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_direct;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (tick_source_select[0] == SEL_DIRECT && !prescaler_clear) |=> timer_zero_tick;
  endproperty
  a_direct: assert property (p_direct) else $error("direct select missed a tick");
  property p_stop;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (tick_source_select[1] == SEL_STOP) |=> !timer_one_tick;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer ticked");
  property p_stop0;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (tick_source_select[0] == SEL_STOP) |=> !timer_zero_tick;
  endproperty
  a_stop0: assert property (p_stop0) else $error("stopped timer zero ticked");
  property p_direct1;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (tick_source_select[1] == SEL_DIRECT && !prescaler_clear) |=> timer_one_tick;
  endproperty
  a_direct1: assert property (p_direct1) else $error("direct select missed a tick");
  // a select change inside the window hands the timer to another source
  property p_div8;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (tick_source_select[0] == SEL_DIV8 && timer_zero_tick) |=>
      (!timer_zero_tick || tick_source_select[0] != SEL_DIV8)[*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 too fast");
  // a plain reset request, without hold, must not outlive its write
  property p_selfclear;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (gtc_write && pwdata[`GTC_PSR_BIT] && !pwdata[`GTC_HOLD_BIT])
      |=> !prescaler_reset_request;
  endproperty
  a_selfclear: assert property (p_selfclear) else $error("reset request stuck");
  property p_hold;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (prescaler_reset_request && sync_hold_mode && !gtc_write) |=> prescaler_reset_request;
  endproperty
  a_hold: assert property (p_hold) else $error("held request lost");
  property p_release;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (sync_hold_mode && gtc_write && !pwdata[`GTC_HOLD_BIT])
      |=> (!prescaler_reset_request && !sync_hold_mode);
  endproperty
  a_release: assert property (p_release) else $error("hold release kept request");
  property p_cleared;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    prescaler_clear |=> (prescale_count == '0);
  endproperty
  a_cleared: assert property (p_cleared) else $error("prescaler not reset");
  // internal sources stay quiet while the prescaler is held in reset
  property p_halted;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (prescaler_clear && tick_source_select[0] != SEL_EXT_RISE &&
      tick_source_select[0] != SEL_EXT_FALL) |=> !timer_zero_tick;
  endproperty
  a_halted: assert property (p_halted) else $error("timer ticked during reset");
  sequence s_rise;
    pin_sync && !pin_prev;
  endsequence
  sequence s_fall;
    !pin_sync && pin_prev;
  endsequence
  property p_rise;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (tick_source_select[0] == SEL_EXT_RISE) ##0 s_rise |=> timer_zero_tick;
  endproperty
  a_rise: assert property (p_rise) else $error("rising pin edge missed");
  property p_fall;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    (tick_source_select[1] == SEL_EXT_FALL) ##0 s_fall |=> timer_one_tick;
  endproperty
  a_fall: assert property (p_fall) else $error("falling pin edge missed");
  property p_capsel;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    !capture_input_choice ##1 !capture_input_choice |-> capture_trigger == $past(cap_sync[0]);
  endproperty
  a_capsel: assert property (p_capsel) else $error("capture routed wrong");
  property p_capsel_b;
    @(posedge sys_clk) disable iff (!rst_ok_n)
    capture_input_choice ##1 capture_input_choice |-> capture_trigger == $past(cap_sync[1]);
  endproperty
  a_capsel_b: assert property (p_capsel_b) else $error("capture pin b routed wrong");

endmodule : shared_timer_prescaler
`default_nettype wire

// File: prescaler_defs.svh
// offsets, field positions, reset values and timing counts for the shared prescaler
`ifndef PRESCALER_DEFS_SVH
`define PRESCALER_DEFS_SVH
`define GTC_OFFSET 12'h000
`define TICK0_SEL_OFFSET 12'h004
`define TICK1_SEL_OFFSET 12'h008
`define STATUS_OFFSET 12'h00C
`define GTC_HOLD_BIT 7
`define GTC_CAPSEL_BIT 6
`define GTC_PSR_BIT 0
`define GTC_RESET 8'h00
`define SEL_RESET 3'h0
`define PRESCALE_WIDTH 10
`define SYS_CLK_HZ 10000000
`define SYNC_STAGES 2
`endif

// File: prescaler_pkg.sv
// types shared by the prescaler block
`default_nettype none
package prescaler_pkg;
  typedef enum logic [2:0] {
    SEL_STOP = 3'h0, SEL_DIRECT = 3'h1, SEL_DIV8 = 3'h2, SEL_DIV64 = 3'h3,
    SEL_DIV256 = 3'h4, SEL_DIV1024 = 3'h5, SEL_EXT_FALL = 3'h6, SEL_EXT_RISE = 3'h7
  } tick_source_t;
endpackage : prescaler_pkg
`default_nettype wire

// File: tick_partner.sv
// far side model: count pin source and tick counters for both timers
`default_nettype none
module tick_partner (
  // clock
  input wire logic sys_clk,
  // ticks from the block
  input wire logic timer_zero_tick,
  input wire logic timer_one_tick,
  // count pin
  output logic external_count_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int zero_count = 0;
  int one_count = 0;
  initial external_count_pin = 1'b0;
  always @(posedge sys_clk) begin
    if (timer_zero_tick === 1'b1) zero_count <= zero_count + 1;
    if (timer_one_tick === 1'b1) one_count <= one_count + 1;
  end
  // half is kept at two cycles or more so every level is sampled at least once
  task automatic pulses(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      external_count_pin <= 1'b1;
      repeat (half) @(posedge sys_clk);
      external_count_pin <= 1'b0;
      repeat (half - 1) @(posedge sys_clk);
    end
  endtask : pulses
  task automatic rise_delay(output int cyc);
    @(posedge sys_clk);
    external_count_pin <= 1'b1;
    cyc = 0;
    while (timer_zero_tick !== 1'b1 && cyc < 10) begin
      @(negedge sys_clk);
      cyc++;
    end
    repeat (3) @(posedge sys_clk);
    external_count_pin <= 1'b0;
  endtask : rise_delay
endmodule : tick_partner
`default_nettype wire

// File: test_shared_timer_prescaler.sv
// self-checking testbench for the shared timer prescaler
`default_nettype none
`include "prescaler_defs.svh"
module test_shared_timer_prescaler
  import prescaler_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin;
  logic cap_a = 1'b0;
  logic cap_b = 1'b0;
  logic tick0;
  logic tick1;
  logic trig;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int z;
  int o;
  int cyc;
  tick_source_t codes [6] = '{SEL_DIRECT, SEL_DIV8, SEL_DIV64, SEL_DIV256, SEL_DIV1024, SEL_STOP};
  int divs [6] = '{1, 8, 64, 256, 1024, 0};
  always #50 sys_clk = ~sys_clk;
  shared_timer_prescaler i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_pin(pin), .capture_pin_a(cap_a), .capture_pin_b(cap_b),
    .timer_zero_tick(tick0), .timer_one_tick(tick1), .capture_trigger(trig));
  tick_partner i_partner (.sys_clk(sys_clk), .timer_zero_tick(tick0), .timer_one_tick(tick1),
    .external_count_pin(pin));
  // ****************************************
  // bus cycles and comparisons
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // ****************************************
  // scenarios
  // ****************************************
  task automatic reg_reset_and_unmapped();
    apb(1'b0, `GTC_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, `TICK1_SEL_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b1, 12'h010, 32'h0000_00C1);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(rd, 32'h0000_0000);
  endtask : reg_reset_and_unmapped
  task automatic tap_rates();
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `TICK0_SEL_OFFSET, {29'h0, codes[i]});
      apb(1'b1, `TICK1_SEL_OFFSET, {29'h0, codes[(i + 3) % 6]});
      repeat (4) @(negedge sys_clk);
      z = i_partner.zero_count;
      o = i_partner.one_count;
      repeat (2048) @(negedge sys_clk);
      check(i_partner.zero_count - z, divs[i] ? 2048 / divs[i] : 0);
      check(i_partner.one_count - o, divs[(i + 3) % 6] ? 2048 / divs[(i + 3) % 6] : 0);
    end
  endtask : tap_rates
  task automatic hold_and_pin();
    apb(1'b1, `GTC_OFFSET, 32'h0000_0081);
    apb(1'b0, `GTC_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0081);
    // selects change while the prescaler is held in reset
    apb(1'b1, `TICK0_SEL_OFFSET, {29'h0, SEL_DIV8});
    apb(1'b1, `TICK1_SEL_OFFSET, {29'h0, SEL_DIV64});
    z = i_partner.zero_count;
    o = i_partner.one_count;
    repeat (200) @(negedge sys_clk);
    check(i_partner.zero_count - z + i_partner.one_count - o, 0);
    apb(1'b0, `STATUS_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b1, `GTC_OFFSET, 32'h0000_0000);
    z = i_partner.zero_count;
    o = i_partner.one_count;
    repeat (66) @(negedge sys_clk);
    check(i_partner.zero_count - z, 8);
    check(i_partner.one_count - o, 1);
    apb(1'b0, `GTC_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b1, `GTC_OFFSET, 32'h0000_0081);
    apb(1'b1, `TICK0_SEL_OFFSET, {29'h0, SEL_EXT_RISE});
    apb(1'b1, `TICK1_SEL_OFFSET, {29'h0, SEL_EXT_FALL});
    z = i_partner.zero_count;
    o = i_partner.one_count;
    i_partner.pulses(5, 3);
    repeat (8) @(negedge sys_clk);
    check(i_partner.zero_count - z, 5);
    check(i_partner.one_count - o, 5);
    i_partner.rise_delay(cyc);
    check(cyc, 4);
    apb(1'b1, `GTC_OFFSET, 32'h0000_0001);
    apb(1'b0, `GTC_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0000);
  endtask : hold_and_pin
  task automatic capture_choice();
    cap_a <= 1'b1;
    repeat (5) @(negedge sys_clk);
    check({31'h0, trig}, 32'h0000_0001);
    apb(1'b1, `GTC_OFFSET, 32'h0000_0040);
    repeat (5) @(negedge sys_clk);
    check({31'h0, trig}, 32'h0000_0000);
    @(posedge sys_clk);
    cap_b <= 1'b1;
    repeat (5) @(negedge sys_clk);
    check({31'h0, trig}, 32'h0000_0001);
  endtask : capture_choice
  // hang guard: the full run needs about 12750 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reg_reset_and_unmapped();
    tap_rates();
    hold_and_pin();
    capture_choice();
    complete_run();
  end
endmodule : test_shared_timer_prescaler
`default_nettype wire
